// ==== inc/rpsel_defs.svh ====
// constants for the remappable output pin select block
`ifndef RPSEL_DEFS_SVH
`define RPSEL_DEFS_SVH
`define RPSEL_ADDR_OSEL01 4'h0
`define RPSEL_ADDR_OSEL23 4'h4
`define RPSEL_ADDR_OSC_CTRL 4'h8
`define RPSEL_SEL_LO_LSB 0
`define RPSEL_SEL_HI_LSB 8
`define RPSEL_LOCK_BIT 6
`define RPSEL_KEY1 8'h46
`define RPSEL_KEY2 8'h57
`define RPSEL_SEL_RESET 6'h00
`define RPSEL_NULL_SEL 6'h00
`endif

// ==== inc/rpsel_pkg.sv ====
// types for the remappable output pin select block
package rpsel_pkg;
  typedef enum logic [1:0] {
    RPSEL_KEY_IDLE = 2'b00,
    RPSEL_KEY_GOT1 = 2'b01,
    RPSEL_KEY_OPEN = 2'b10
  } rpsel_key_t;
  typedef struct packed {
    logic [3:0][5:0] sel;
    logic lock;
    logic one_way;
    logic armed;
    rpsel_key_t key;
    logic ack;
    logic [31:0] rdata;
  } rpsel_state_t;
endpackage

// ==== verilog/rpsel_top.sv ====
// remappable output pin select with wishbone register access
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "rpsel_defs.svh"
// What this block does
// - pin 0 driven by peripheral output numbered by register 0 bits 5-0
// - pin 1 driven by peripheral output numbered by register 0 bits 13-8
// - pin 2 driven by peripheral output numbered by register 1 bits 5-0
// - pin 3 driven by peripheral output numbered by register 1 bits 13-8
// - bits 15-14 and 7-6 ignore writes and read zero
// - selector bits are read/write and reset to zero
// - selector zero disconnects the pin from all peripheral outputs
// - lock blocks selector writes; lock changes only after key sequence
// - with one-way option, a set lock stays until reset
module rpsel_top
  import rpsel_pkg::*;
#(
  parameter int NUM_PERIPH = 64
)
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic one_way_lock_option_in,
  input wire logic [NUM_PERIPH-1:0] periph_out_in,
  output logic [3:0] remappable_pin_out,
  output logic mapping_lock_out
);

  // the selector is 6 bits wide, so more than 64 sources cannot be reached
  if (NUM_PERIPH < 2 || NUM_PERIPH > 64)
  begin : g_bad_num_periph
    $error("NUM_PERIPH must lie in 2..64");
  end

  rpsel_state_t st_ff;
  rpsel_state_t nxt_st;
  logic req;
  logic wr;
  logic [3:0] pin_map;

  assign req = wb_cyc_in && wb_stb_in && !st_ff.ack;
  assign wr = req && wb_we_in;

  ////////////////////////////////////////////////////////////////////
  // register file and unlock sequencer
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ack = req;
    nxt_st.rdata = 32'h0000_0000;
    // option sampled once after reset release; async reset may not load a port
    if (!st_ff.armed)
    begin
      nxt_st.armed = 1'b1;
      nxt_st.one_way = one_way_lock_option_in;
    end
    if (req && !wb_we_in)
    begin
      case (wb_adr_in)
        `RPSEL_ADDR_OSEL01:
        begin
          nxt_st.rdata[`RPSEL_SEL_LO_LSB +: 6] = st_ff.sel[0];
          nxt_st.rdata[`RPSEL_SEL_HI_LSB +: 6] = st_ff.sel[1];
        end
        `RPSEL_ADDR_OSEL23:
        begin
          nxt_st.rdata[`RPSEL_SEL_LO_LSB +: 6] = st_ff.sel[2];
          nxt_st.rdata[`RPSEL_SEL_HI_LSB +: 6] = st_ff.sel[3];
        end
        `RPSEL_ADDR_OSC_CTRL:
        begin
          nxt_st.rdata[`RPSEL_LOCK_BIT] = st_ff.lock;
        end
        default:
        begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (wr)
    begin
      case (wb_adr_in)
        `RPSEL_ADDR_OSEL01, `RPSEL_ADDR_OSEL23:
        begin
          nxt_st.key = RPSEL_KEY_IDLE;
          if (!st_ff.lock)
          begin
            if (wb_sel_in[0])
            begin
              nxt_st.sel[{wb_adr_in[2], 1'b0}] = wb_dat_in[`RPSEL_SEL_LO_LSB +: 6];
            end
            if (wb_sel_in[1])
            begin
              nxt_st.sel[{wb_adr_in[2], 1'b1}] = wb_dat_in[`RPSEL_SEL_HI_LSB +: 6];
            end
          end
        end
        `RPSEL_ADDR_OSC_CTRL:
        begin
          if (wb_sel_in[0])
          begin
            nxt_st.key = RPSEL_KEY_IDLE;
            case (st_ff.key)
              RPSEL_KEY_IDLE:
              begin
                if (wb_dat_in[7:0] == `RPSEL_KEY1)
                begin
                  nxt_st.key = RPSEL_KEY_GOT1;
                end
              end
              RPSEL_KEY_GOT1:
              begin
                if (wb_dat_in[7:0] == `RPSEL_KEY2)
                begin
                  nxt_st.key = RPSEL_KEY_OPEN;
                end
                else if (wb_dat_in[7:0] == `RPSEL_KEY1)
                begin
                  nxt_st.key = RPSEL_KEY_GOT1;
                end
              end
              RPSEL_KEY_OPEN:
              begin
                // the write right after the key decides the lock
                if (!(st_ff.lock && st_ff.one_way))
                begin
                  nxt_st.lock = wb_dat_in[`RPSEL_LOCK_BIT];
                end
              end
              default:
              begin
                nxt_st.key = RPSEL_KEY_IDLE;
              end
            endcase
          end
        end
        default:
        begin
          nxt_st.key = RPSEL_KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st_ff.sel <= {4{`RPSEL_SEL_RESET}};
      st_ff.lock <= 1'b0;
      st_ff.one_way <= 1'b0;
      st_ff.armed <= 1'b0;
      st_ff.key <= RPSEL_KEY_IDLE;
      st_ff.ack <= 1'b0;
      st_ff.rdata <= 32'h0000_0000;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output crossbar; peripheral outputs share this clock so no sync
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      always_comb
      begin
        pin_map[gi] = 1'b0;
        if (st_ff.sel[gi] != `RPSEL_NULL_SEL && 32'(st_ff.sel[gi]) < NUM_PERIPH)
        begin
          pin_map[gi] = periph_out_in[st_ff.sel[gi]];
        end
      end
    end
  endgenerate

  assign remappable_pin_out = pin_map;
  assign mapping_lock_out = st_ff.lock;
  assign wb_ack_out = st_ff.ack;
  assign wb_dat_out = st_ff.rdata;

  ////////////////////////////////////////////////////////////////////
  // checks
  // each step of the unlock key is a lane 0 write to the control register
  sequence s_key_first;
    wr && wb_adr_in == `RPSEL_ADDR_OSC_CTRL && wb_sel_in[0] && st_ff.key == RPSEL_KEY_IDLE
      && wb_dat_in[7:0] == `RPSEL_KEY1;
  endsequence

  sequence s_key_second;
    wr && wb_adr_in == `RPSEL_ADDR_OSC_CTRL && wb_sel_in[0] && st_ff.key == RPSEL_KEY_GOT1
      && wb_dat_in[7:0] == `RPSEL_KEY2;
  endsequence

  sequence s_key_done;
    wr && wb_adr_in == `RPSEL_ADDR_OSC_CTRL && wb_sel_in[0] && st_ff.key == RPSEL_KEY_OPEN;
  endsequence

  property p_pin0_map;
    @(posedge mclk_in) disable iff (reset_in)
    (st_ff.sel[0] == 6'h01) |-> remappable_pin_out[0] == periph_out_in[1];
  endproperty
  a_pin0_map: assert property (p_pin0_map) else $error("pin 0 map wrong");

  property p_pin3_map;
    @(posedge mclk_in) disable iff (reset_in)
    (st_ff.sel[3] == 6'h02) |-> remappable_pin_out[3] == periph_out_in[2];
  endproperty
  a_pin3_map: assert property (p_pin3_map) else $error("pin 3 map wrong");

  property p_null;
    @(posedge mclk_in) disable iff (reset_in)
    (st_ff.sel[1] == 6'h00) |-> !remappable_pin_out[1];
  endproperty
  a_null: assert property (p_null) else $error("null select drives pin");

  property p_rsvd_zero;
    @(posedge mclk_in) disable iff (reset_in)
    wb_ack_out |-> wb_dat_out[15:14] == 2'b00 && wb_dat_out[7:6] == 2'b00
      || $past(wb_adr_in) == `RPSEL_ADDR_OSC_CTRL;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

  property p_locked_hold;
    @(posedge mclk_in) disable iff (reset_in)
    (st_ff.lock && wr && wb_adr_in != `RPSEL_ADDR_OSC_CTRL) |=> $stable(st_ff.sel);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("write through lock");

  property p_lock_needs_key;
    @(posedge mclk_in) disable iff (reset_in)
    $changed(st_ff.lock) |-> $past(st_ff.key) == RPSEL_KEY_OPEN;
  endproperty
  a_lock_needs_key: assert property (p_lock_needs_key) else $error("lock moved w/o key");

  property p_one_way;
    @(posedge mclk_in) disable iff (reset_in)
    (st_ff.lock && st_ff.one_way) |=> st_ff.lock;
  endproperty
  a_one_way: assert property (p_one_way) else $error("one-way lock cleared");

  property p_key_lock;
    @(posedge mclk_in) disable iff (reset_in)
    (s_key_done ##0 !st_ff.one_way) |=> st_ff.lock == $past(wb_dat_in[`RPSEL_LOCK_BIT]);
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("keyed lock write lost");

  property p_ack_once;
    @(posedge mclk_in) disable iff (reset_in)
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack timing wrong");

  property p_pin1_map;
    @(posedge mclk_in) disable iff (reset_in)
    (st_ff.sel[1] != `RPSEL_NULL_SEL && 32'(st_ff.sel[1]) < NUM_PERIPH)
      |-> remappable_pin_out[1] == periph_out_in[st_ff.sel[1]];
  endproperty
  a_pin1_map: assert property (p_pin1_map) else $error("pin 1 map wrong");

  property p_pin2_map;
    @(posedge mclk_in) disable iff (reset_in)
    (st_ff.sel[2] != `RPSEL_NULL_SEL && 32'(st_ff.sel[2]) < NUM_PERIPH)
      |-> remappable_pin_out[2] == periph_out_in[st_ff.sel[2]];
  endproperty
  a_pin2_map: assert property (p_pin2_map) else $error("pin 2 map wrong");

  property p_hi_zero;
    @(posedge mclk_in) disable iff (reset_in)
    wb_ack_out |-> wb_dat_out[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits nonzero");

  property p_idle_data;
    @(posedge mclk_in) disable iff (reset_in)
    !wb_ack_out |-> wb_dat_out == 32'h0000_0000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside ack");

  property p_sel_write;
    @(posedge mclk_in) disable iff (reset_in)
    (wr && wb_adr_in == `RPSEL_ADDR_OSEL01 && wb_sel_in[0] && !st_ff.lock)
      |=> st_ff.sel[0] == $past(wb_dat_in[`RPSEL_SEL_LO_LSB +: 6]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector write lost");

  property p_key_got1;
    @(posedge mclk_in) disable iff (reset_in)
    s_key_first |=> st_ff.key == RPSEL_KEY_GOT1;
  endproperty
  a_key_got1: assert property (p_key_got1) else $error("first key byte lost");

  property p_key_open;
    @(posedge mclk_in) disable iff (reset_in)
    s_key_second |=> st_ff.key == RPSEL_KEY_OPEN;
  endproperty
  a_key_open: assert property (p_key_open) else $error("second key byte lost");

  property p_key_close;
    @(posedge mclk_in) disable iff (reset_in)
    s_key_done |=> st_ff.key == RPSEL_KEY_IDLE;
  endproperty
  a_key_close: assert property (p_key_close) else $error("key left open");

endmodule

// ==== bench/rpsel_periph_model.sv ====
// peripheral output sources feeding the remappable output pins
`timescale 1ns/1ps
module rpsel_periph_model
(
  input wire logic mclk_in,
  input wire logic reset_in,
  output logic [63:0] periph_out
);
  logic [63:0] pat_ff;
  // pattern moves every cycle so a stale or wrong selector shows up at once
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      pat_ff <= 64'h0123_4567_89ab_cdef;
    else
      pat_ff <= {pat_ff[62:0], pat_ff[63] ^ pat_ff[60]};
  end
  assign periph_out = pat_ff;
endmodule

// ==== bench/test_rpsel_top.sv ====
// self-checking testbench for the remappable output pin select block
`timescale 1ns/1ps
module test_rpsel_top;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0000_0000;
  logic opt = 1'b0;
  logic [63:0] periph;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] pins;
  logic lock;
  logic [31:0] rnd = 32'h0000_9429;
  int err_total = 0;
  int compares = 0;
  int m[4];
  always #2 mclk_in = ~mclk_in;
  rpsel_periph_model rpsel_periph_model_inst (.mclk_in(mclk_in), .reset_in(reset_in),
    .periph_out(periph));
  rpsel_top rpsel_top_inst (.mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .one_way_lock_option_in(opt),
    .periph_out_in(periph), .remappable_pin_out(pins), .mapping_lock_out(lock));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_reg(input int r);
    return {18'h0_0000, m[2*r+1][5:0], 2'h0, m[2*r][5:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // classic cycle: hold until ack is seen on a rising edge, then release
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    @(posedge mclk_in);
    while (ack !== 1'b1)
    begin
      @(posedge mclk_in);
      n++;
      if (n > 20)
      begin
        err_total++;
        end_of_test();
      end
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(nm, q, exp);
  endtask
  task automatic pin_chk();
    @(negedge mclk_in);
    for (int i = 0; i < 4; i++)
      chk("pin", {31'h0, pins[i]}, {31'h0, (m[i] == 0) ? 1'b0 : periph[m[i]]});
    @(posedge mclk_in);
  endtask
  task automatic key_lock(input logic v);
    wr(4'h8, 32'h0000_0046);
    wr(4'h8, 32'h0000_0057);
    wr(4'h8, {25'h0, v, 6'h00});
  endtask
  task automatic do_reset(input logic o);
    reset_in <= 1'b1;
    opt <= o;
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    m = '{0, 0, 0, 0};
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int r;
    logic [31:0] q;
    do_reset(1'b0);
    rd_chk("osel01", 4'h0, 32'h0000_0000);
    rd_chk("osel23", 4'h4, 32'h0000_0000);
    pin_chk();
    $display("test reset done");
    for (int k = 0; k < 12; k++)
    begin
      r = k % 2;
      rnd = lfsr(rnd);
      wr(r ? 4'h4 : 4'h0, rnd);
      m[2*r] = rnd[5:0];
      m[2*r+1] = rnd[13:8];
      rd_chk("osel", r ? 4'h4 : 4'h0, exp_reg(r));
      pin_chk();
    end
    wr(4'h0, 32'h0000_0001);
    wr(4'h4, 32'h0000_0200);
    m = '{1, 0, 0, 2};
    pin_chk();
    rnd = lfsr(rnd);
    bus(1'b1, 4'h0, rnd, 4'h2, q);
    m[1] = rnd[13:8];
    rd_chk("lane", 4'h0, exp_reg(0));
    pin_chk();
    $display("test mapping done");
    wr(4'h8, 32'h0000_0040);
    chk("lock", {31'h0, lock}, 32'h0000_0000);
    wr(4'h8, 32'h0000_0057);
    wr(4'h8, 32'h0000_0046);
    wr(4'h8, 32'h0000_0040);
    chk("lock", {31'h0, lock}, 32'h0000_0000);
    key_lock(1'b1);
    chk("lock", {31'h0, lock}, 32'h0000_0001);
    wr(4'h0, 32'h0000_3f3f);
    rd_chk("osel01", 4'h0, exp_reg(0));
    pin_chk();
    wr(4'h8, 32'h0000_0046);
    wr(4'h0, 32'h0000_0000);
    wr(4'h8, 32'h0000_0057);
    wr(4'h8, 32'h0000_0000);
    chk("lock", {31'h0, lock}, 32'h0000_0001);
    key_lock(1'b0);
    chk("lock", {31'h0, lock}, 32'h0000_0000);
    rd_chk("unmapped", 4'hc, 32'h0000_0000);
    $display("test lock done");
    do_reset(1'b1);
    key_lock(1'b1);
    key_lock(1'b0);
    chk("lock", {31'h0, lock}, 32'h0000_0001);
    wr(4'h0, 32'h0000_0101);
    rd_chk("osel01", 4'h0, 32'h0000_0000);
    $display("test one way done");
    end_of_test();
  end
endmodule
